// >>> design/urtc_pkg.sv
// shared constants and types for the unit read transfer checker
package urtc_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0C;
  localparam logic [7:0] ADDR_LAST_CNT  = 8'h10;

  // control register fields
  localparam int CTRL_EXT_FAMILY_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status register fields
  localparam int STAT_ERR_BIT  = 0;
  localparam int STAT_EQ_BIT   = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_USED_BIT = 3;

  // interrupt event bits
  localparam int IRQ_W         = 3;
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_ERR_BIT   = 1;
  localparam int IRQ_FAIL_BIT  = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // operand limits
  localparam logic [15:0] MAX_WORDS      = 16'h0080;
  localparam logic [15:0] MAX_IND_DM     = 16'h1A00;
  localparam logic [7:0]  MAX_UNIT_NO    = 8'h0F;
  localparam logic [3:0]  MAX_BANK       = 4'hC;
  localparam logic [15:0] MAX_EXT_OFFSET = 16'h7FFF;
  localparam logic [15:0] CTRL_VAR_XFER  = 16'hFD00;

  // one instruction request from the execution logic
  typedef struct packed {
    logic [15:0] ctrl_code;
    logic        is_write;
    logic [7:0]  unit_no;
    logic [15:0] word_count;
    logic [15:0] dest_addr;
    logic [3:0]  dest_bank;
    logic        banked;
    logic        indirect;
    logic        remote_rack;
  } urtc_req_t;

  // one destination store toward controller memory
  typedef struct packed {
    logic [3:0]  bank;
    logic [15:0] addr;
    logic [15:0] data;
  } urtc_store_t;

endpackage : urtc_pkg

// >>> design/urtc_top.sv
// unit read transfer checker: operand checks, flags, word copy, wishbone registers
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
module urtc_top #(
  parameter int WB_AW = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone classic slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [WB_AW-1:0]      wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  output logic                       irq_o,
  // instruction execution side
  input  wire logic                  scan_start_i,
  input  wire logic                  req_valid_i,
  input  wire urtc_pkg::urtc_req_t   req_i,
  output logic                       req_ready_o,
  output logic                       done_o,
  output logic                       exec_error_flag_o,
  output logic                       completion_equal_flag_o,
  output logic                       scan_used_o,
  // add-on unit side
  output logic                       unit_req_o,
  output logic                       unit_busy_o,
  input  wire logic                  unit_vld_i,
  input  wire logic [15:0]           unit_data_i,
  input  wire logic                  unit_fail_i,
  // destination memory stores
  output logic                       mem_we_o,
  output urtc_pkg::urtc_store_t      mem_store_o
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_bcd16(input logic [15:0] v);
    is_bcd16 = (v[3:0] < 4'hA) && (v[7:4] < 4'hA) && (v[11:8] < 4'hA) && (v[15:12] < 4'hA);
  endfunction : is_bcd16

  function automatic logic [15:0] bcd16_to_bin(input logic [15:0] v);
    logic [15:0] r;
    r = 16'(v[15:12]) * 16'h03E8 + 16'(v[11:8]) * 16'h0064
      + 16'(v[7:4]) * 16'h000A + 16'(v[3:0]);
    bcd16_to_bin = r;
  endfunction : bcd16_to_bin

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_XFER, ST_DONE} urtc_state_t;

  urtc_state_t          state_reg;
  urtc_pkg::urtc_req_t  req_reg;
  logic [31:0]          ctrl_reg;
  logic [urtc_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [urtc_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [15:0]          idx_reg;
  logic [15:0]          cnt_bin_reg;
  logic [15:0]          base_reg;
  logic [15:0]          last_cnt_reg;
  logic                 used_reg;
  logic                 err_reg;
  logic                 eq_reg;

  logic                 ext_family;
  logic                 is_var_xfer;
  logic                 take;
  logic                 bad_count;
  logic                 bad_dest;
  logic                 bad_unit;
  logic                 bad_any;
  logic                 last_word;
  logic [15:0]          cnt_bin;
  logic [15:0]          dest_bin;
  logic [urtc_pkg::IRQ_W-1:0] irq_ev;

  assign ext_family  = ctrl_reg[urtc_pkg::CTRL_EXT_FAMILY_BIT];
  assign is_var_xfer = req_i.ctrl_code == urtc_pkg::CTRL_VAR_XFER;
  // a second variable transfer in the same scan stays pending
  assign take = req_valid_i && req_ready_o && !(is_var_xfer && used_reg);

  ////////////////////////////////////////////////////////////////////////////
  // operand checks on the latched request
  assign cnt_bin = bcd16_to_bin(req_reg.word_count);
  assign bad_count = !is_bcd16(req_reg.word_count) || (cnt_bin == 16'h0000)
                   || (cnt_bin > urtc_pkg::MAX_WORDS);

  always_comb begin
    bad_dest = 1'b0;
    dest_bin = req_reg.dest_addr;
    if (ext_family) begin
      if (req_reg.banked && (req_reg.dest_bank > urtc_pkg::MAX_BANK)) begin
        bad_dest = 1'b1;
      end
      if (req_reg.indirect) begin
        dest_bin = bcd16_to_bin(req_reg.dest_addr);
        bad_dest = bad_dest || !is_bcd16(req_reg.dest_addr);
      end
      if (dest_bin > urtc_pkg::MAX_EXT_OFFSET) begin
        bad_dest = 1'b1;
      end
    end else if (req_reg.indirect) begin
      dest_bin = bcd16_to_bin(req_reg.dest_addr);
      bad_dest = !is_bcd16(req_reg.dest_addr)
              || (dest_bin > urtc_pkg::MAX_IND_DM);
    end
  end

  assign bad_unit = (req_reg.unit_no > urtc_pkg::MAX_UNIT_NO) || req_reg.remote_rack;
  assign bad_any  = bad_count || bad_dest || bad_unit;
  assign last_word = unit_vld_i && ((idx_reg + 16'h0001) == cnt_bin_reg);

  ////////////////////////////////////////////////////////////////////////////
  // instruction sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg   <= ST_IDLE;
      req_reg     <= '0;
      req_ready_o <= 1'b0;
      done_o      <= 1'b0;
      cnt_bin_reg <= 16'h0000;
      base_reg    <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          req_ready_o <= 1'b1;
          if (take) begin
            req_reg     <= req_i;
            req_ready_o <= 1'b0;
            state_reg   <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          cnt_bin_reg <= cnt_bin;
          base_reg    <= dest_bin;
          // a rejected instruction never reaches the unit
          state_reg   <= bad_any ? ST_DONE : ST_XFER;
        end
        ST_XFER: begin
          if (unit_fail_i || last_word) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          done_o      <= 1'b1;
          req_ready_o <= 1'b1;
          state_reg   <= ST_IDLE;
        end
      endcase
    end
  end

  // one variable transfer per scan; a new scan frees the slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      used_reg <= 1'b0;
    end else if (take && is_var_xfer) begin
      used_reg <= 1'b1;
    end else if (scan_start_i) begin
      used_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_reg <= 1'b0;
    end else if (state_reg == ST_CHECK) begin
      err_reg <= bad_any;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eq_reg <= 1'b0;
    end else if (take) begin
      eq_reg <= 1'b0;
    end else if ((state_reg == ST_XFER) && last_word && !unit_fail_i) begin
      eq_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // unit exchange and destination stores
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit_req_o   <= 1'b0;
      unit_busy_o  <= 1'b0;
      idx_reg      <= 16'h0000;
      last_cnt_reg <= 16'h0000;
      mem_we_o     <= 1'b0;
      mem_store_o  <= '0;
    end else begin
      mem_we_o <= 1'b0;
      if ((state_reg == ST_CHECK) && !bad_any) begin
        unit_req_o  <= 1'b1;
        unit_busy_o <= 1'b1;
        idx_reg     <= 16'h0000;
      end else if (state_reg == ST_XFER) begin
        if (unit_vld_i && !unit_fail_i) begin
          idx_reg  <= idx_reg + 16'h0001;
          // write instructions move data the other way; only reads store here
          mem_we_o <= !req_reg.is_write;
          mem_store_o.bank <= req_reg.banked ? req_reg.dest_bank : 4'h0;
          mem_store_o.addr <= base_reg + idx_reg;
          mem_store_o.data <= unit_data_i;
        end
        if (unit_fail_i || last_word) begin
          unit_req_o   <= 1'b0;
          unit_busy_o  <= 1'b0;
          last_cnt_reg <= unit_fail_i ? idx_reg : idx_reg + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: hardware set beats a write-one clear in the same cycle
  always_comb begin
    irq_ev = '0;
    irq_ev[urtc_pkg::IRQ_DONE_BIT] = (state_reg == ST_XFER) && last_word && !unit_fail_i;
    irq_ev[urtc_pkg::IRQ_ERR_BIT]  = (state_reg == ST_CHECK) && bad_any;
    irq_ev[urtc_pkg::IRQ_FAIL_BIT] = (state_reg == ST_XFER) && unit_fail_i;
  end

  logic wb_req;
  logic wb_wr;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= urtc_pkg::IRQ_RESET;
    end else if (wb_wr && (wb_adr_i == WB_AW'(urtc_pkg::ADDR_IRQ_STAT))) begin
      irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[urtc_pkg::IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone register file, one-cycle ack, unmapped reads as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg     <= urtc_pkg::CTRL_RESET;
      irq_mask_reg <= urtc_pkg::IRQ_RESET;
    end else if (wb_wr) begin
      if (wb_adr_i == WB_AW'(urtc_pkg::ADDR_CTRL)) begin
        ctrl_reg[7:0] <= wb_dat_i[7:0] & 8'h01;
      end
      if (wb_adr_i == WB_AW'(urtc_pkg::ADDR_IRQ_MASK)) begin
        irq_mask_reg <= wb_dat_i[urtc_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          WB_AW'(urtc_pkg::ADDR_CTRL):     wb_dat_o <= ctrl_reg;
          WB_AW'(urtc_pkg::ADDR_STATUS):   wb_dat_o <= {28'h0000000, used_reg, unit_busy_o,
                                                        eq_reg, err_reg};
          WB_AW'(urtc_pkg::ADDR_IRQ_STAT): wb_dat_o <= 32'(irq_stat_reg);
          WB_AW'(urtc_pkg::ADDR_IRQ_MASK): wb_dat_o <= 32'(irq_mask_reg);
          WB_AW'(urtc_pkg::ADDR_LAST_CNT): wb_dat_o <= 32'(last_cnt_reg);
          default:                         wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign exec_error_flag_o       = err_reg;
  assign completion_equal_flag_o = eq_reg;
  assign scan_used_o             = used_reg;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_err_count;
    (state_reg == ST_CHECK) && bad_count |=> exec_error_flag_o && !unit_req_o;
  endproperty
  a_err_count: assert property (p_err_count) else $error("bad count not flagged");

  property p_err_dest;
    (state_reg == ST_CHECK) && !ext_family && req_reg.indirect && (dest_bin > 16'h1A00)
      |=> exec_error_flag_o;
  endproperty
  a_err_dest: assert property (p_err_dest) else $error("bad destination not flagged");

  property p_err_unit;
    (state_reg == ST_CHECK) && (req_reg.unit_no > 8'h0F || req_reg.remote_rack)
      |=> exec_error_flag_o;
  endproperty
  a_err_unit: assert property (p_err_unit) else $error("bad unit not flagged");

  property p_err_clear;
    (state_reg == ST_CHECK) && !bad_any |=> !exec_error_flag_o ##0 unit_busy_o;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");

  property p_eq_set;
    (state_reg == ST_XFER) && last_word && !unit_fail_i |=> completion_equal_flag_o ##1 done_o;
  endproperty
  a_eq_set: assert property (p_eq_set) else $error("equals not set on completion");

  property p_eq_clear;
    take |=> !completion_equal_flag_o [*2];
  endproperty
  a_eq_clear: assert property (p_eq_clear) else $error("equals not cleared at start");

  property p_one_per_scan;
    req_valid_i && is_var_xfer && scan_used_o && req_ready_o |=> req_ready_o;
  endproperty
  a_one_per_scan: assert property (p_one_per_scan) else $error("second transfer in scan");

  property p_busy_store;
    mem_we_o |-> $past(unit_busy_o);
  endproperty
  a_busy_store: assert property (p_busy_store) else $error("store while not busy");

  property p_ascending;
    mem_we_o ##1 mem_we_o |-> mem_store_o.addr == $past(mem_store_o.addr) + 16'h0001;
  endproperty
  a_ascending: assert property (p_ascending) else $error("stores not ascending");

  property p_bank_limit;
    mem_we_o && ext_family |-> mem_store_o.bank <= 4'hC;
  endproperty
  a_bank_limit: assert property (p_bank_limit) else $error("bank above limit");

  c_good_read: cover property ((state_reg == ST_XFER) ##[1:200] completion_equal_flag_o);
  c_bad_count: cover property ((state_reg == ST_CHECK) && bad_count);
  c_scan_wait: cover property (req_valid_i && is_var_xfer && used_reg && req_ready_o);
  c_unit_fail: cover property ((state_reg == ST_XFER) && unit_fail_i);

endmodule : urtc_top

// >>> verification/urtc_top_bench.sv
// self-checking bench for the unit read transfer checker
`timescale 1ns/1ps
module urtc_top_bench;
  typedef struct {
    logic                ext;
    urtc_pkg::urtc_req_t r;
    logic                xerr;
    int                  nw;
  } urtc_row_t;
  logic clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, irq, scan_start, req_valid, req_ready;
  logic done, err, eq, used, unit_req, busy, vld, ufail, mem_we;
  logic [7:0]            wb_adr, fail_at;
  logic [3:0]            wb_sel, gap;
  logic [31:0]           wb_dat, wb_rdat, q;
  logic [15:0]           udata;
  urtc_pkg::urtc_req_t   req, r0;
  urtc_pkg::urtc_store_t store;
  urtc_pkg::urtc_store_t st[$];
  urtc_row_t             rows[15];
  int                    failures, checks_done, t;

  urtc_top #(.WB_AW(8)) dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq_o(irq), .scan_start_i(scan_start),
    .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready), .done_o(done),
    .exec_error_flag_o(err), .completion_equal_flag_o(eq), .scan_used_o(used),
    .unit_req_o(unit_req), .unit_busy_o(busy), .unit_vld_i(vld), .unit_data_i(udata),
    .unit_fail_i(ufail), .mem_we_o(mem_we), .mem_store_o(store));
  urtc_unit_model unit (.clk_i(clk), .rst_i(rst), .unit_req_i(unit_req), .gap_i(gap),
    .fail_at_i(fail_at), .unit_vld_o(vld), .unit_data_o(udata), .unit_fail_o(ufail));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (mem_we === 1'b1) st.push_back(store);
    if (unit_req === 1'b1) check(busy, 1);
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      failures++;
      tally_and_finish();
    end
  endtask : give_up
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dat <= d; wb_sel <= 4'hF;
    n = 0;
    do begin @(posedge clk); n++; end while (wb_ack !== 1'b1 && n < 50);
    give_up(n, 50);
    q = wb_rdat;
    wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
    @(posedge clk);
  endtask : wb
  // one instruction: wait for idle unit, hand over, wait for done
  task automatic run(input urtc_pkg::urtc_req_t r, input logic xerr, input logic xeq,
                     input int nw);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin @(posedge clk); n++; end
    give_up(n, 100);
    st.delete();
    req <= r;
    req_valid <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end
    while (!(req_ready === 1'b1 && !(r.ctrl_code == urtc_pkg::CTRL_VAR_XFER && used === 1'b1))
           && n < 200);
    give_up(n, 200);
    req_valid <= 1'b0;
    @(posedge clk);
    check(eq, 0);
    n = 0;
    while (done !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
    give_up(n, 2000);
    check(err, xerr);
    check(eq, xeq);
    check(st.size(), nw);
    foreach (st[k]) begin
      check(st[k].data, 16'hA000 + k);
      check(st[k].bank, r.banked ? r.dest_bank : 4'h0);
      if (!r.indirect) check(st[k].addr, r.dest_addr + k);
    end
  endtask : run
  function automatic urtc_row_t mk(logic x, logic w, logic [7:0] u, logic [15:0] c,
    logic [15:0] a, logic [3:0] b, logic bk, logic ind, logic rem, logic e, int n);
    mk.ext = x;
    mk.xerr = e;
    mk.nw = n;
    mk.r = '{ctrl_code: 16'h0000, is_write: w, unit_no: u, word_count: c, dest_addr: a,
             dest_bank: b, banked: bk, indirect: ind, remote_rack: rem};
  endfunction : mk
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 0; rst = 1; wb_cyc = 0; wb_stb = 0; wb_we = 0; wb_adr = 8'h00; wb_sel = 4'h0;
    // gap 0 gives back-to-back words, so consecutive stores are exercised
    wb_dat = 32'h0; scan_start = 0; req_valid = 0; req = '0; gap = 4'h0; fail_at = 8'hFF;
    failures = 0; checks_done = 0;
    rows = '{mk(0,0,8'h03,16'h0002,16'h0100,4'h0,0,0,0,0,2),
      mk(0,0,8'h03,16'h0000,16'h0100,4'h0,0,0,0,1,0), mk(0,0,8'h03,16'h0129,16'h0,4'h0,0,0,0,1,0),
      mk(0,0,8'h03,16'h0128,16'h0200,4'h0,0,0,0,0,128),
      mk(0,0,8'h03,16'h00A1,16'h0,4'h0,0,0,0,1,0), mk(0,0,8'h03,16'h0001,16'h6656,4'h0,0,1,0,0,1),
      mk(0,0,8'h03,16'h0001,16'h6657,4'h0,0,1,0,1,0), mk(0,0,8'h03,16'h0001,16'h1A00,4'h0,0,1,0,1,0),
      mk(0,0,8'h0F,16'h0003,16'h0300,4'h0,0,0,0,0,3), mk(0,0,8'h10,16'h0001,16'h0,4'h0,0,0,0,1,0),
      mk(0,0,8'h03,16'h0001,16'h0,4'h0,0,0,1,1,0), mk(0,1,8'h03,16'h0004,16'h0400,4'h0,0,0,0,0,0),
      mk(1,0,8'h03,16'h0001,16'h7FFF,4'hC,1,0,0,0,1), mk(1,0,8'h03,16'h0001,16'h0010,4'hD,1,0,0,1,0),
      mk(1,0,8'h03,16'h0001,16'h8000,4'h0,0,0,0,1,0)};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({req_ready, done, err, eq, used, unit_req, busy, mem_we, irq, wb_ack}, 0);
    wb(1, 8'h20, 32'hFFFF_FFFF);
    foreach (rows[i]) if (i < 6) begin
      wb(0, (i == 5) ? 8'h20 : 8'(4 * i), 32'h0);
      check(q, 0);
    end
    foreach (rows[i]) begin
      wb(1, urtc_pkg::ADDR_CTRL, {31'h0, rows[i].ext});
      run(rows[i].r, rows[i].xerr, !rows[i].xerr, rows[i].nw);
    end
    // slow unit; first try aborts mid-transfer, requester retries
    gap <= 4'h3;
    wb(1, urtc_pkg::ADDR_CTRL, 32'h0);
    run(rows[0].r, 0, 1, 2);
    wb(0, urtc_pkg::ADDR_LAST_CNT, 32'h0);
    check(q, 2);
    for (t = 0; t < 3 && (t == 0 || eq !== 1'b1); t++) begin
      fail_at <= (t == 0) ? 8'h01 : 8'hFF;
      run(rows[0].r, 0, t != 0, (t == 0) ? 1 : 2);
    end
    check(t, 2);
    wb(1, urtc_pkg::ADDR_IRQ_STAT, 32'h7);
    wb(1, urtc_pkg::ADDR_IRQ_MASK, 32'h0);
    run(rows[1].r, 1, 0, 0);
    repeat (2) @(posedge clk);
    check(irq, 0);
    wb(0, urtc_pkg::ADDR_IRQ_STAT, 32'h0);
    check(q, 32'h2);
    wb(1, urtc_pkg::ADDR_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk);
    check(irq, 1);
    wb(1, urtc_pkg::ADDR_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clk);
    check(irq, 0);
    // second variable transfer in one scan must wait for the next scan
    r0 = rows[0].r;
    r0.ctrl_code = urtc_pkg::CTRL_VAR_XFER;
    run(r0, 0, 1, 2);
    fork
      run(r0, 0, 1, 2);
      begin
        repeat (20) @(posedge clk);
        check({req_ready, used}, 2'b11);
        scan_start <= 1'b1;
        @(posedge clk);
        scan_start <= 1'b0;
      end
    join
    wb(0, urtc_pkg::ADDR_STATUS, 32'h0);
    check(q, 32'hA);
    wb(1, urtc_pkg::ADDR_CTRL, 32'h1);
    wb(0, urtc_pkg::ADDR_CTRL, 32'h0);
    check(q, 32'h1);
    // mid-run reset with the slot used and equals set
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({req_ready, done, err, eq, used, unit_req, busy, mem_we, irq, wb_ack}, 0);
    wb(0, urtc_pkg::ADDR_CTRL, 32'h0);
    check(q, 32'h0);
    wb(0, urtc_pkg::ADDR_STATUS, 32'h0);
    check(q, 32'h0);
    tally_and_finish();
  end
endmodule : urtc_top_bench

// >>> verification/urtc_unit_model.sv
// add-on unit model: answers word requests, may stall or abort
`timescale 1ns/1ps
module urtc_unit_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        unit_req_i,
  input  wire logic [3:0]  gap_i,
  input  wire logic [7:0]  fail_at_i,
  output logic             unit_vld_o,
  output logic [15:0]      unit_data_o,
  output logic             unit_fail_o
);
  logic [3:0] wait_reg;
  logic [7:0] idx_reg;
  // idle data toggles so a stale word never passes as fresh
  always @(posedge clk_i) begin
    unit_vld_o  <= 1'b0;
    unit_fail_o <= 1'b0;
    unit_data_o <= rst_i ? 16'h5555 : ~unit_data_o;
    if (rst_i || !unit_req_i) begin
      wait_reg <= 4'h0;
      idx_reg  <= 8'h00;
    end else if (wait_reg < gap_i) begin
      wait_reg <= wait_reg + 4'h1;
    end else begin
      wait_reg <= 4'h0;
      idx_reg  <= idx_reg + 8'h01;
      if (idx_reg == fail_at_i) begin
        unit_fail_o <= 1'b1;
      end else begin
        unit_vld_o  <= 1'b1;
        unit_data_o <= 16'hA000 + {8'h00, idx_reg};
      end
    end
  end
endmodule : urtc_unit_model
